// File: core/stp_prescaler.sv
`timescale 1ns/1ns
module stp_prescaler
	import stp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [1:0] ext_count_pin,
	output logic [1:0] timer_clock_tick
);
	logic [9:0] psc_cnt;
	logic [9:0] next_psc_cnt;
	logic [2:0] sel0;
	logic [2:0] sel1;
	logic [2:0] next_sel0;
	logic [2:0] next_sel1;
	stp_bus_t bus_state;
	stp_bus_t next_bus_state;
	logic [31:0] next_readdata;
	logic next_waitrequest;
	logic wr_take;
	logic psr_hit;
	logic [3:0] taps;

	stp_src_if src0 ();
	stp_src_if src1 ();

	////////////////////////////////////////////////////////////////////////
	// bus slave

	// a write lands only at the edge where waitrequest is seen low
	assign wr_take = avs_write & (bus_state == STP_BUS_ANS);
	assign psr_hit = wr_take & (avs_address == STP_ADDR_SFIO) & avs_byteenable[0]
		& avs_writedata[STP_PSR_BIT];

	// one wait cycle per access, answer in the second
	always_comb begin
		next_bus_state = STP_BUS_IDLE;
		next_readdata = avs_readdata;
		case (bus_state)
			STP_BUS_IDLE: begin
				if (avs_read | avs_write) begin
					next_bus_state = STP_BUS_ANS;
				end
				next_readdata = STP_RD_ZERO;
				if (avs_read) begin
					case (avs_address)
						STP_ADDR_SFIO: next_readdata = STP_RD_ZERO;
						STP_ADDR_SEL0: next_readdata = {29'h0000_0000, sel0};
						STP_ADDR_SEL1: next_readdata = {29'h0000_0000, sel1};
						STP_ADDR_STAT: next_readdata = {22'h00_0000, psc_cnt};
						default: next_readdata = STP_RD_ZERO;
					endcase
				end
			end
			STP_BUS_ANS: next_bus_state = STP_BUS_IDLE;
			default: next_bus_state = STP_BUS_IDLE;
		endcase
		next_waitrequest = (next_bus_state != STP_BUS_ANS);
	end

	// independent selection per timer
	always_comb begin
		next_sel0 = sel0;
		next_sel1 = sel1;
		if (wr_take & avs_byteenable[0]) begin
			if (avs_address == STP_ADDR_SEL0) begin
				next_sel0 = avs_writedata[2:0];
			end
			if (avs_address == STP_ADDR_SEL1) begin
				next_sel1 = avs_writedata[2:0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			bus_state <= STP_BUS_IDLE;
			avs_readdata <= STP_RD_ZERO;
			avs_waitrequest <= 1'b1;
			sel0 <= STP_SEL_STOP;
			sel1 <= STP_SEL_STOP;
		end else begin
			bus_state <= next_bus_state;
			avs_readdata <= next_readdata;
			avs_waitrequest <= next_waitrequest;
			sel0 <= next_sel0;
			sel1 <= next_sel1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// shared prescaler

	// never gated by selection; a zero write leaves it alone
	always_comb begin
		if (psr_hit) begin
			next_psc_cnt = STP_CNT_ZERO;
		end else begin
			next_psc_cnt = psc_cnt + STP_CNT_ONE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			psc_cnt <= STP_CNT_ZERO;
		end else begin
			psc_cnt <= next_psc_cnt;
		end
	end

	// taps are shared so both timers see the same phase
	assign taps[0] = stp_tap_hit(psc_cnt, STP_MASK_DIV8);
	assign taps[1] = stp_tap_hit(psc_cnt, STP_MASK_DIV64);
	assign taps[2] = stp_tap_hit(psc_cnt, STP_MASK_DIV256);
	assign taps[3] = stp_tap_hit(psc_cnt, STP_MASK_DIV1024);
	assign src0.tap = taps;
	assign src1.tap = taps;

	////////////////////////////////////////////////////////////////////////
	// per-timer sources

	stp_pin_edge u_edge0 (
		.core_clk(core_clk),
		.rstn(rstn),
		.pin(ext_count_pin[0]),
		.src(src0)
	);

	stp_pin_edge u_edge1 (
		.core_clk(core_clk),
		.rstn(rstn),
		.pin(ext_count_pin[1]),
		.src(src1)
	);

	stp_clk_sel u_sel0 (
		.core_clk(core_clk),
		.rstn(rstn),
		.sel(sel0),
		.src(src0),
		.tick(timer_clock_tick[0])
	);

	stp_clk_sel u_sel1 (
		.core_clk(core_clk),
		.rstn(rstn),
		.sel(sel1),
		.src(src1),
		.tick(timer_clock_tick[1])
	);

	////////////////////////////////////////////////////////////////////////
	// checks

	// select 1 must tick on every cycle after it is set
	property p_direct;
		@(posedge core_clk) disable iff (!rstn)
		(sel0 == STP_SEL_DIRECT) |=> timer_clock_tick[0];
	endproperty
	a_direct: assert property (p_direct) else $error("direct select missed a tick");

	// a stopped timer sees no tick from the cycle after the stop lands
	property p_stop;
		@(posedge core_clk) disable iff (!rstn)
		(sel1 == STP_SEL_STOP) |=> !timer_clock_tick[1];
	endproperty
	a_stop: assert property (p_stop) else $error("stopped timer ticked");

	// tick follows the tap hit by exactly one edge
	property p_div8;
		@(posedge core_clk) disable iff (!rstn)
		(sel0 == STP_SEL_DIV8) |=> (timer_clock_tick[0] == ($past(psc_cnt[2:0]) == 3'h7));
	endproperty
	a_div8: assert property (p_div8) else $error("divide by 8 tick misplaced");

	// worst case: the tap hit just passed when the selection landed
	property p_first_count;
		@(posedge core_clk) disable iff (!rstn)
		($changed(sel1) && sel1 == STP_SEL_DIV8) |-> ##[1:9] timer_clock_tick[1];
	endproperty
	a_first_count: assert property (p_first_count) else $error("first prescaled tick too late");

	// divider never pauses, whatever the selections are
	property p_free_run;
		@(posedge core_clk) disable iff (!rstn)
		!psr_hit |=> (psc_cnt == $past(psc_cnt) + STP_CNT_ONE);
	endproperty
	a_free_run: assert property (p_free_run) else $error("prescaler did not advance");

	// restart gives a full first period on the smallest tap
	property p_psr;
		@(posedge core_clk) disable iff (!rstn)
		psr_hit |=> (psc_cnt == STP_CNT_ZERO) ##7 (psc_cnt[2:0] == 3'h7);
	endproperty
	a_psr: assert property (p_psr) else $error("prescaler reset did not restart count");

	property p_psr_read;
		@(posedge core_clk) disable iff (!rstn)
		(bus_state == STP_BUS_ANS && avs_read && avs_address == STP_ADDR_SFIO) |-> (avs_readdata == STP_RD_ZERO);
	endproperty
	a_psr_read: assert property (p_psr_read) else $error("reset bit read non-zero");

	// pin sampled high at the first edge, two flops and the tick flop follow
	property p_ext_rise;
		@(posedge core_clk) disable iff (!rstn)
		(sel0 == STP_SEL_EXT_RISE && $rose(ext_count_pin[0])) ##1 (sel0 == STP_SEL_EXT_RISE) ##1 (sel0 == STP_SEL_EXT_RISE)
		|-> ##1 timer_clock_tick[0] ##1 !timer_clock_tick[0];
	endproperty
	a_ext_rise: assert property (p_ext_rise) else $error("pin rise did not give one tick");

	// same path for the falling edge on the second timer
	property p_ext_fall;
		@(posedge core_clk) disable iff (!rstn)
		(sel1 == STP_SEL_EXT_FALL && $fell(ext_count_pin[1])) ##1 (sel1 == STP_SEL_EXT_FALL) ##1 (sel1 == STP_SEL_EXT_FALL)
		|-> ##1 timer_clock_tick[1] ##1 !timer_clock_tick[1];
	endproperty
	a_ext_fall: assert property (p_ext_fall) else $error("pin fall did not give one tick");

	// no edge, no tick: external source never borrows a prescaler tap
	property p_ext_nodiv;
		@(posedge core_clk) disable iff (!rstn)
		(sel0 == STP_SEL_EXT_RISE && !src0.rise) |=> !timer_clock_tick[0];
	endproperty
	a_ext_nodiv: assert property (p_ext_nodiv) else $error("external tick without pin edge");

	// a zero in the reset bit must leave the divider running on
	property p_zero_write;
		@(posedge core_clk) disable iff (!rstn)
		(wr_take && avs_address == STP_ADDR_SFIO && !avs_writedata[STP_PSR_BIT])
		|=> (psc_cnt == $past(psc_cnt) + STP_CNT_ONE);
	endproperty
	a_zero_write: assert property (p_zero_write) else $error("zero write disturbed prescaler");

	// selections change only through an accepted write
	property p_sel_hold;
		@(posedge core_clk) disable iff (!rstn)
		!wr_take |=> ($stable(sel0) && $stable(sel1));
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("selection changed without a write");

	// second timer on the /64 tap shares the divider phase
	property p_tap64;
		@(posedge core_clk) disable iff (!rstn)
		(sel1 == STP_SEL_DIV64) |=> (timer_clock_tick[1] == stp_tap_hit($past(psc_cnt), STP_MASK_DIV64));
	endproperty
	a_tap64: assert property (p_tap64) else $error("divide by 64 tick misplaced");

	// exactly one wait cycle, then waitrequest back high
	property p_wait;
		@(posedge core_clk) disable iff (!rstn)
		((avs_read || avs_write) && avs_waitrequest && bus_state == STP_BUS_IDLE) |=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("bus answer not in one cycle");

	c_direct: cover property (@(posedge core_clk) disable iff (!rstn) sel0 == STP_SEL_DIRECT ##1 timer_clock_tick[0]);
	c_psr: cover property (@(posedge core_clk) disable iff (!rstn) psr_hit);
	c_ext: cover property (@(posedge core_clk) disable iff (!rstn) sel1 == STP_SEL_EXT_FALL && timer_clock_tick[1]);
	c_div1024: cover property (@(posedge core_clk) disable iff (!rstn) sel0 == STP_SEL_DIV1024 && timer_clock_tick[0]);
	c_ext_rise: cover property (@(posedge core_clk) disable iff (!rstn) sel0 == STP_SEL_EXT_RISE && timer_clock_tick[0]);
endmodule

// File: core/stp_pkg.sv
package stp_pkg;

	// register byte offsets on the avalon slave
	localparam logic [3:0] STP_ADDR_SFIO = 4'h0;
	localparam logic [3:0] STP_ADDR_SEL0 = 4'h4;
	localparam logic [3:0] STP_ADDR_SEL1 = 4'h8;
	localparam logic [3:0] STP_ADDR_STAT = 4'hc;

	// field layout
	localparam int STP_PSR_BIT = 0;
	localparam int STP_SEL_W = 3;
	localparam int STP_PSC_W = 10;
	localparam logic [31:0] STP_RD_ZERO = 32'h0000_0000;

	// clock selection codes
	typedef enum logic [2:0] {
		STP_SEL_STOP = 3'h0,
		STP_SEL_DIRECT = 3'h1,
		STP_SEL_DIV8 = 3'h2,
		STP_SEL_DIV64 = 3'h3,
		STP_SEL_DIV256 = 3'h4,
		STP_SEL_DIV1024 = 3'h5,
		STP_SEL_EXT_FALL = 3'h6,
		STP_SEL_EXT_RISE = 3'h7
	} stp_sel_t;

	// prescaler count masks, one per tap
	localparam logic [9:0] STP_MASK_DIV8 = 10'h007;
	localparam logic [9:0] STP_MASK_DIV64 = 10'h03f;
	localparam logic [9:0] STP_MASK_DIV256 = 10'h0ff;
	localparam logic [9:0] STP_MASK_DIV1024 = 10'h3ff;
	localparam logic [9:0] STP_CNT_ZERO = 10'h000;
	localparam logic [9:0] STP_CNT_ONE = 10'h001;

	// bus answer states
	typedef enum logic [1:0] {
		STP_BUS_IDLE = 2'b01,
		STP_BUS_ANS = 2'b10
	} stp_bus_t;

	// a tap fires on the last count of its period
	function automatic logic stp_tap_hit(input logic [9:0] cnt, input logic [9:0] mask);
		return (cnt & mask) == mask;
	endfunction

endpackage

// File: core/stp_src_if.sv
`timescale 1ns/1ns
interface stp_src_if;
	logic [3:0] tap;
	logic rise;
	logic fall;
	modport edge_src (output rise, output fall);
	modport sink (input tap, input rise, input fall);
endinterface

// File: core/stp_pin_edge.sv
`timescale 1ns/1ns
module stp_pin_edge
	import stp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic pin,
	stp_src_if.edge_src src
);
	logic sync1;
	logic sync2;
	logic prev;
	logic next_sync1;
	logic next_sync2;
	logic next_prev;

	// pin sampled once a cycle; first stage only feeds the second
	always_comb begin
		next_sync1 = pin;
		next_sync2 = sync1;
		next_prev = sync2;
	end

	// rising-edge registers stand in for the half-cycle latch
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			prev <= 1'b0;
		end else begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			prev <= next_prev;
		end
	end

	// edge detector on synchronised samples only
	assign src.rise = sync2 & ~prev;
	assign src.fall = ~sync2 & prev;
endmodule

// File: core/stp_clk_sel.sv
`timescale 1ns/1ns
module stp_clk_sel
	import stp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [2:0] sel,
	stp_src_if.sink src,
	output logic tick
);
	logic next_tick;

	// one tick source per selection code
	function automatic logic pick(input logic [2:0] s, input logic [3:0] t, input logic r, input logic f);
		case (s)
			STP_SEL_STOP: pick = 1'b0;
			STP_SEL_DIRECT: pick = 1'b1;
			STP_SEL_DIV8: pick = t[0];
			STP_SEL_DIV64: pick = t[1];
			STP_SEL_DIV256: pick = t[2];
			STP_SEL_DIV1024: pick = t[3];
			STP_SEL_EXT_FALL: pick = f;
			STP_SEL_EXT_RISE: pick = r;
			default: pick = 1'b0;
		endcase
	endfunction

	// external edges bypass the divider entirely
	always_comb begin
		next_tick = pick(sel, src.tap, src.rise, src.fall);
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			tick <= 1'b0;
		end else begin
			tick <= next_tick;
		end
	end
endmodule

// File: dv/stp_pin_src.sv
`timescale 1ns/1ns
// far-side count source: square wave of half cycles, stands still while run is low
module stp_pin_src (
	input wire logic core_clk,
	input wire logic run,
	input wire logic [7:0] half,
	output logic pin
);
	logic [7:0] cnt;
	initial begin
		cnt = 8'h00;
		pin = 1'b0;
	end
	// each level held for half cycles, only one cycle when half is 0 or 1
	always @(posedge core_clk) begin
		if (!run) begin
			cnt <= 8'h00;
		end else if (cnt + 8'h01 >= half) begin
			cnt <= 8'h00;
			pin <= ~pin;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule

// File: dv/shared_timer_prescaler_bench.sv
`timescale 1ns/1ns
module shared_timer_prescaler_bench;
	import stp_pkg::*;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [1:0] pins;
	logic [1:0] tick;
	logic run = 1'b0;
	logic [7:0] half = 8'h03;
	logic [31:0] rd;
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;

	stp_prescaler i_dut (
		.core_clk(core_clk),
		.rstn(rstn),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(4'hf),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.ext_count_pin(pins),
		.timer_clock_tick(tick)
	);
	stp_pin_src i_src0 (.core_clk(core_clk), .run(run), .half(half), .pin(pins[0]));
	stp_pin_src i_src1 (.core_clk(core_clk), .run(run), .half(half), .pin(pins[1]));

	////////////////////////////////////////////////////////////////
	// clock and hang guard, ceiling well above the ~13k cycles of tests
	initial begin
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			bad_count++;
			close_out();
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one avalon transfer; held until the rising edge that samples waitrequest low,
	// read data taken at that same edge, released right after it
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	function automatic int per(input int code, input int len);
		case (code)
			1: return len;
			2: return len / 8;
			3: return len / 64;
			4: return len / 256;
			5: return len / 1024;
			default: return 0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////
	task test_regs;
		bus(1'b0, STP_ADDR_SEL1, 32'h0);
		check(rd, 32'h0);
		bus(1'b1, STP_ADDR_SEL0, 32'h5);
		bus(1'b0, STP_ADDR_SEL0, 32'h0);
		check(rd, 32'h5);
		bus(1'b0, 4'h2, 32'h0);
		check(rd, 32'h0);
		bus(1'b1, STP_ADDR_SFIO, 32'h1);
		bus(1'b0, STP_ADDR_SFIO, 32'h0);
		check(rd, 32'h0);
		$display("test regs done");
	endtask

	// every internal code on timer0, a different one on timer1; 2048 spans all taps
	task test_taps;
		int c0;
		int c1;
		for (int s = 0; s < 6; s++) begin
			bus(1'b1, STP_ADDR_SEL0, 32'(s));
			bus(1'b1, STP_ADDR_SEL1, 32'(5 - s));
			repeat (4) @(posedge core_clk);
			c0 = 0;
			c1 = 0;
			repeat (2048) begin
				@(negedge core_clk);
				c0 += int'(tick[0] === 1'b1);
				c1 += int'(tick[1] === 1'b1);
			end
			check(32'(c0), 32'(per(s, 2048)));
			check(32'(c1), 32'(per(5 - s, 2048)));
		end
		$display("test taps done");
	endtask

	task test_reset;
		int k0;
		int k1;
		bus(1'b1, STP_ADDR_SEL0, 32'h2);
		bus(1'b1, STP_ADDR_SEL1, 32'h3);
		bus(1'b1, STP_ADDR_SFIO, 32'h1);
		k0 = 0;
		k1 = 0;
		for (int k = 1; k <= 100; k++) begin
			@(negedge core_clk);
			if (tick[0] === 1'b1 && k0 == 0) k0 = k;
			if (tick[1] === 1'b1 && k1 == 0) k1 = k;
		end
		// count zero at the write edge, tap hit n-1 edges on, tick one edge later,
		// seen at the falling edge after it
		check(32'(k0), 32'd9);
		check(32'(k1), 32'd65);
		bus(1'b1, STP_ADDR_SEL0, 32'h0);
		bus(1'b1, STP_ADDR_SEL1, 32'h0);
		repeat (500) @(posedge core_clk);
		bus(1'b1, STP_ADDR_SFIO, 32'h0);
		bus(1'b0, STP_ADDR_STAT, 32'h0);
		check(32'(rd[9:0] > 10'd500), 32'h1);
		bus(1'b1, STP_ADDR_SFIO, 32'h1);
		bus(1'b0, STP_ADDR_STAT, 32'h0);
		check(32'(rd[9:0] < 10'd8), 32'h1);
		$display("test reset done");
	endtask

	// pins idle while selections change; stopped just after a rise so rises exceed falls
	task test_ext;
		int r0;
		int f1;
		int t0;
		int t1;
		int pr;
		int pt;
		logic [1:0] prev;
		bus(1'b1, STP_ADDR_SEL0, 32'h7);
		bus(1'b1, STP_ADDR_SEL1, 32'h6);
		{r0, f1, t0, t1, pr, pt} = '0;
		prev = pins;
		@(posedge core_clk);
		run <= 1'b1;
		for (int n = 1; n <= 90; n++) begin
			@(negedge core_clk);
			if (pins[0] === 1'b1 && !prev[0]) r0++;
			if (pins[1] === 1'b0 && prev[1]) f1++;
			if (pins[0] === 1'b1 && !prev[0] && pr == 0) pr = n;
			if (tick[0] === 1'b1 && pt == 0) pt = n;
			t0 += int'(tick[0] === 1'b1);
			t1 += int'(tick[1] === 1'b1);
			if (n >= 60 && pins[0] && !prev[0] && run) begin
				prev = pins;
				@(posedge core_clk);
				run <= 1'b0;
			end
			prev = pins;
		end
		check(32'(t0), 32'(r0));
		check(32'(t1), 32'(f1));
		check(32'(pt - pr >= 2 && pt - pr <= 3), 32'h1);
		bus(1'b1, STP_ADDR_SEL0, 32'h0);
		bus(1'b1, STP_ADDR_SEL1, 32'h0);
		$display("test ext done");
	endtask

	task close_out;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		test_regs();
		test_taps();
		test_reset();
		test_ext();
		close_out();
	end
endmodule
